// ===== xor_swap_pkg.sv
package xor_swap_pkg;

  // operand and data widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned NIB_LO = 0;
  localparam int unsigned NIB_W  = 4;
  localparam int unsigned REG_COUNT = 128;

  // reset values
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;

  // destination select encodings
  localparam logic DEST_WORK = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // instruction select, one-hot
  typedef enum logic [3:0] {
    op_none                  = 4'b0001,
    op_xor_reg_with_work     = 4'b0010,
    op_nibble_exchange       = 4'b0100,
    op_xor_literal_with_work = 4'b1000
  } op_t;

  // one instruction as issued by the sequencer
  typedef struct packed {
    op_t               op;
    logic [ADDR_W-1:0] addr;
    logic              dest;
    logic [DATA_W-1:0] literal;
  } instr_t;

  // status flags seen by the core
  typedef struct packed {
    logic zero;
    logic digit_carry;
    logic carry;
  } status_t;

endpackage : xor_swap_pkg

// ===== data_file_mem.sv
`timescale 1ns/10ps
module data_file_mem (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // read port, data registered
  input  wire logic [6:0] read_addr,
  output logic      [7:0] read_data,
  // write port
  input  wire logic       write_en,
  input  wire logic [6:0] write_addr,
  input  wire logic [7:0] write_data
);

  logic [7:0] cells [xor_swap_pkg::REG_COUNT];

  // cells keep contents over reset, as data ram does
  always_ff @(posedge clock) begin
    if (write_en) begin
      cells[write_addr] <= write_data;
    end
  end

  // registered read; reset gives a defined output
  always_ff @(posedge clock) begin
    if (reset) begin
      read_data <= xor_swap_pkg::ZERO_BYTE;
    end else begin
      read_data <= cells[read_addr];
    end
  end

endmodule : data_file_mem

// ===== xor_swap_datapath.sv
`timescale 1ns/10ps
module xor_swap_datapath (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset,
  // instruction issue
  input  wire logic                  issue_valid,
  input  wire xor_swap_pkg::instr_t  issue,
  output logic                       issue_ready,
  // status flags in from the rest of the core
  input  wire logic                  carry_in,
  input  wire logic                  digit_carry_in,
  // results
  output logic [7:0]                 work,
  output xor_swap_pkg::status_t      status,
  output logic                       done,
  // external data file port for load of operands
  input  wire logic                  load_en,
  input  wire logic [6:0]            load_addr,
  input  wire logic [7:0]            load_data
);

  // two-phase: fetch operand (memory read is registered), then execute
  typedef enum logic [1:0] {
    st_fetch = 2'b01,
    st_exec  = 2'b10
  } state_t;

  state_t               state;
  state_t               next_state;
  xor_swap_pkg::instr_t held;
  logic [7:0]           file_data;
  logic [7:0]           result;
  logic                 zero_touch;
  logic                 to_work;
  logic                 to_file;
  logic                 is_xor_reg;
  logic                 is_swap;
  logic                 is_xor_lit;
  logic                 file_we;
  logic [6:0]           file_waddr;
  logic [7:0]           file_wdata;

  function automatic logic [7:0] swap_nibbles(input logic [7:0] v);
    swap_nibbles = {v[xor_swap_pkg::NIB_LO +: xor_swap_pkg::NIB_W],
                    v[xor_swap_pkg::NIB_W +: xor_swap_pkg::NIB_W]};
  endfunction : swap_nibbles

  // one instruction in flight; a new one only in the fetch phase
  // a second issue cannot arrive while the first writes back, which
  // keeps the operand read on the take edge clear of a pending write
  assign issue_ready = (state == st_fetch);
  assign next_state  = (state == st_fetch && issue_valid) ? st_exec : st_fetch;

  // decode of the held instruction
  assign is_xor_reg = (held.op == xor_swap_pkg::op_xor_reg_with_work);
  assign is_swap    = (held.op == xor_swap_pkg::op_nibble_exchange);
  assign is_xor_lit = (held.op == xor_swap_pkg::op_xor_literal_with_work);

  // result select
  // register xor operand
  assign result = is_xor_reg ? (work ^ file_data) :
                  is_xor_lit ? (work ^ held.literal) :
                  is_swap    ? swap_nibbles(file_data) : work;

  // destination steering
  // swap and register xor follow dest
  assign to_file    = (is_xor_reg || is_swap) && held.dest == xor_swap_pkg::DEST_FILE;
  assign to_work    = is_xor_lit || ((is_xor_reg || is_swap) && held.dest == xor_swap_pkg::DEST_WORK);
  // only the xors touch a flag
  assign zero_touch = is_xor_reg || is_xor_lit;

  // file write mux: execute write-back wins over external load
  // limitation: a load in the same cycle as a write-back is lost
  assign file_we    = (state == st_exec && to_file) || load_en;
  assign file_waddr = (state == st_exec && to_file) ? held.addr : load_addr;
  assign file_wdata = (state == st_exec && to_file) ? result : load_data;

  // read launched from the issue bus itself, so the operand is ready in
  // the execute cycle; issue.addr must stand at the take edge
  // 7-bit address reaches all 128 registers
  data_file_mem u_file (
    .clock      (clock),
    .reset      (reset),
    .read_addr  (issue.addr),
    .read_data  (file_data),
    .write_en   (file_we),
    .write_addr (file_waddr),
    .write_data (file_wdata)
  );

  // state and held instruction
  // the held copy lets the issue bus move on once the instruction is taken
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= st_fetch;
      held  <= '{op: xor_swap_pkg::op_none, addr: '0, dest: 1'b0, literal: '0};
    end else begin
      state <= next_state;
      if (issue_ready && issue_valid) begin
        held <= issue;
      end
    end
  end

  // working register
  // only results steered to work land here; file results leave it alone
  always_ff @(posedge clock) begin
    if (reset) begin
      work <= xor_swap_pkg::WORK_RESET;
    end else if (state == st_exec && to_work) begin
      work <= result;
    end
  end

  // flags; carry and digit carry pass through untouched
  // those two belong to other instructions, so they are kept current
  always_ff @(posedge clock) begin
    if (reset) begin
      status <= '0;
      done   <= 1'b0;
    end else begin
      done               <= (state == st_exec);
      status.carry       <= carry_in;
      status.digit_carry <= digit_carry_in;
      if (state == st_exec && zero_touch) begin
        status.zero <= (result == xor_swap_pkg::ZERO_BYTE);
      end
    end
  end

  // assertions, one rule each; all are quiet while reset is high

  swap_no_flag_a: assert property (@(posedge clock) disable iff (reset)
    (state == st_exec && is_swap) |=> $stable(status.zero))
    else $error("swap changed zero flag");

  swap_file_data_a: assert property (@(posedge clock) disable iff (reset)
    (state == st_exec && is_swap && held.dest) |-> file_wdata == {file_data[3:0], file_data[7:4]})
    else $error("swap to file data wrong");

  lit_to_work_a: assert property (@(posedge clock) disable iff (reset)
    (state == st_exec && is_xor_lit) |=> work == ($past(work) ^ $past(held.literal)))
    else $error("literal xor result wrong");

  lit_no_file_a: assert property (@(posedge clock) disable iff (reset)
    (state == st_exec && is_xor_lit) |-> file_we == load_en)
    else $error("literal xor wrote the data file");

  zero_value_a: assert property (@(posedge clock) disable iff (reset)
    (state == st_exec && zero_touch) |=> status.zero == ($past(result) == xor_swap_pkg::ZERO_BYTE))
    else $error("zero flag wrong");

  zero_hold_a: assert property (@(posedge clock) disable iff (reset)
    !(state == st_exec && zero_touch) |=> $stable(status.zero))
    else $error("zero flag moved outside an xor");

  xor_reg_work_a: assert property (@(posedge clock) disable iff (reset)
    (state == st_exec && is_xor_reg && !held.dest) |=> work == ($past(work) ^ $past(file_data)))
    else $error("register xor to work wrong");

  xor_reg_file_a: assert property (@(posedge clock) disable iff (reset)
    (state == st_exec && is_xor_reg && held.dest) |->
      file_we && file_waddr == held.addr && file_wdata == (work ^ file_data) ##1 $stable(work))
    else $error("register xor to file wrong");

  carry_kept_a: assert property (@(posedge clock) disable iff (reset)
    (state == st_exec) |=> status.carry == $past(carry_in) && status.digit_carry == $past(digit_carry_in))
    else $error("carry flags altered");

  swap_dest_a: assert property (@(posedge clock) disable iff (reset)
    (state == st_exec && is_swap && held.dest) |-> file_we && file_waddr == held.addr ##1 $stable(work))
    else $error("swap to file misrouted");

  swap_work_a: assert property (@(posedge clock) disable iff (reset)
    (state == st_exec && is_swap && !held.dest) |=> work == {$past(file_data[3:0]), $past(file_data[7:4])})
    else $error("swap to work wrong");

  work_dest_a: assert property (@(posedge clock) disable iff (reset)
    (state == st_exec && is_swap && held.dest == xor_swap_pkg::DEST_WORK) |-> file_we == load_en)
    else $error("swap to work wrote the data file");

  take_addr_a: assert property (@(posedge clock) disable iff (reset)
    (issue_valid && issue_ready) |=> held.addr == $past(issue.addr) && held.dest == $past(issue.dest))
    else $error("operand address or destination lost");

  issue_done_a: assert property (@(posedge clock) disable iff (reset)
    (issue_valid && issue_ready) |=> ##1 done)
    else $error("done not two cycles after issue");

  // covers for the main scenarios: each destination of the register xor,
  // a swap to any destination and one to file, and a literal xor that clears work
  cover_xor_reg_c: cover property (@(posedge clock) state == st_exec && is_xor_reg && held.dest);
  cover_xor_work_c: cover property (@(posedge clock) state == st_exec && is_xor_reg && !held.dest);
  cover_swap_c: cover property (@(posedge clock) state == st_exec && is_swap);
  cover_swap_file_c: cover property (@(posedge clock) state == st_exec && is_swap && held.dest);
  cover_lit_zero_c: cover property (@(posedge clock) state == st_exec && is_xor_lit && result == 8'h00);

endmodule : xor_swap_datapath

// ===== testbench.sv
`timescale 1ns/10ps
module testbench;
  logic                  clock;
  logic                  reset;
  logic                  issue_valid;
  xor_swap_pkg::instr_t  issue;
  logic                  issue_ready;
  logic                  carry_in;
  logic                  digit_carry_in;
  logic [7:0]            work;
  xor_swap_pkg::status_t status;
  logic                  done;
  logic                  load_en;
  logic [6:0]            load_addr;
  logic [7:0]            load_data;
  int                    failures;
  int                    num_checks;
  int                    cycles;

`define CHECK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("FAIL t=%0t got %h want %h", $time, got, exp); \
  end \
end

  xor_swap_datapath dut (
    .clock(clock), .reset(reset), .issue_valid(issue_valid), .issue(issue),
    .issue_ready(issue_ready), .carry_in(carry_in), .digit_carry_in(digit_carry_in),
    .work(work), .status(status), .done(done),
    .load_en(load_en), .load_addr(load_addr), .load_data(load_data)
  );

  // free-running clock, 8 ns period
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // hang guard: whole run needs well under a hundred cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles > 3000) begin
      failures++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // preload one data-file byte, inputs move on falling edges only
  task automatic load(input logic [6:0] a, input logic [7:0] d);
    load_en   = 1'b1;
    load_addr = a;
    load_data = d;
    @(negedge clock);
    load_en = 1'b0;
  endtask : load

  // offer one instruction, hold until taken, return in the done cycle
  task automatic run(input xor_swap_pkg::op_t op, input logic [6:0] a, input logic d, input logic [7:0] k);
    int n;
    issue_valid   = 1'b1;
    issue.op      = op;
    issue.addr    = a;
    issue.dest    = d;
    issue.literal = k;
    n = 0;
    while (issue_ready !== 1'b1 && n < 10) begin
      @(negedge clock);
      n++;
    end
    if (n == 10) begin
      failures++;
      $display("FAIL t=%0t issue never taken", $time);
    end
    // taken at the coming rising edge; the falling edge after it is in the execute cycle
    @(negedge clock);
    issue_valid = 1'b0;
    issue.op    = xor_swap_pkg::op_none;
    `CHECK(issue_ready, 1'b0)
    `CHECK(done, 1'b0)
    // answer stands from the next edge on, done for this one cycle
    @(negedge clock);
    `CHECK(done, 1'b1)
    `CHECK(issue_ready, 1'b1)
  endtask : run

  // literal xor, dest bit must not matter, boundary literals
  task automatic scen_literal;
    run(xor_swap_pkg::op_xor_literal_with_work, 7'h00, 1'b0, 8'ha5);
    `CHECK(work, 8'ha5)
    `CHECK(status.zero, 1'b0)
    run(xor_swap_pkg::op_xor_literal_with_work, 7'h7f, 1'b1, 8'ha5);
    `CHECK(work, 8'h00)
    `CHECK(status.zero, 1'b1)
    run(xor_swap_pkg::op_xor_literal_with_work, 7'h00, 1'b0, 8'hff);
    `CHECK(work, 8'hff)
    `CHECK(status.zero, 1'b0)
  endtask : scen_literal

  // register xor to both destinations, top and bottom addresses
  task automatic scen_reg_xor;
    load(7'h7f, 8'h3c);
    carry_in       = 1'b1;
    digit_carry_in = 1'b1;
    // literal with dest 1 must leave the loaded byte alone
    run(xor_swap_pkg::op_xor_literal_with_work, 7'h7f, 1'b1, 8'h00);
    `CHECK(work, 8'hff)
    run(xor_swap_pkg::op_xor_reg_with_work, 7'h7f, 1'b0, 8'h00);
    `CHECK(work, 8'hff ^ 8'h3c)
    `CHECK(status, 3'b011)
    run(xor_swap_pkg::op_xor_reg_with_work, 7'h7f, 1'b1, 8'h00);
    `CHECK(work, 8'hc3)
    run(xor_swap_pkg::op_xor_reg_with_work, 7'h7f, 1'b0, 8'h00);
    `CHECK(work, 8'hc3 ^ 8'hff)
    load(7'h00, 8'h3c);
    run(xor_swap_pkg::op_xor_reg_with_work, 7'h00, 1'b1, 8'h00);
    `CHECK(work, 8'h3c)
    `CHECK(status, 3'b111)
  endtask : scen_reg_xor

  // swap keeps the zero flag set by the previous xor
  task automatic scen_swap;
    load(7'h40, 8'ha1);
    run(xor_swap_pkg::op_nibble_exchange, 7'h40, 1'b0, 8'h00);
    `CHECK(work, 8'h1a)
    `CHECK(status.zero, 1'b1)
    run(xor_swap_pkg::op_nibble_exchange, 7'h40, 1'b1, 8'h00);
    `CHECK(work, 8'h1a)
    // digit carry dropped so that crossed flag bits would show
    digit_carry_in = 1'b0;
    run(xor_swap_pkg::op_nibble_exchange, 7'h40, 1'b0, 8'h00);
    `CHECK(work, 8'ha1)
    `CHECK(status, 3'b101)
  endtask : scen_swap

  // reset, then the scenarios back to back
  initial begin
    cycles         = 0;
    failures       = 0;
    num_checks     = 0;
    reset          = 1'b1;
    issue_valid    = 1'b0;
    issue          = '0;
    issue.op       = xor_swap_pkg::op_none;
    carry_in       = 1'b0;
    digit_carry_in = 1'b0;
    load_en        = 1'b0;
    load_addr      = 7'h00;
    load_data      = 8'h00;
    repeat (16) @(negedge clock);
    reset = 1'b0;
    `CHECK(work, 8'h00)
    scen_literal();
    scen_reg_xor();
    scen_swap();
    stop_test();
  end
endmodule : testbench
